// File: verilog/qdc_top.sv
//
// Contract
// (RQ1) 24-bit shift register: 8 control, 12 data, 4 ignored bits.
// (RQ2) word arrives msb first, bit 23 leading.
// (RQ3) frame select low starts write; data sampled on sclk falls.
// (RQ4) 24th falling edge captures last bit; later edges ignored.
// (RQ5) decode and execute right after 24th edge, no wait.
// (RQ6) frame select rising early discards partial word, no update.
// (RQ7) next frame begins only at next frame select falling edge.
// (RQ8) host keeps serial clock at or below 50 MHz.
// (RQ9) data code is straight binary, zero to full scale.
// (RQ10) non-broadcast words act only if bits 23,22 match straps; the code runs the three reference command words whatever the straps.
// (RQ11) host always sends bit 19 as zero.
// (RQ12) bits 18,17 select target channel.
// (RQ13) bit 16 marks word as power-down command.
// (RQ14) load 00 writes selected buffer only.
// (RQ15) load 01 writes selected buffer and output register.
// (RQ16) load 10 loads selected new, others from buffers.
// (RQ17) load 11 is broadcast, ignoring strap comparison.
// (RQ18) broadcast with bit 18 low loads all outputs from buffers.
// (RQ19) broadcast with bit 18 high applies word to all channels.
// (RQ20) word 010000h returns reference to automatic mode.
// (RQ21) word 011000h keeps reference always powered.
// (RQ22) word 012000h disables reference, tri-states its output.
// (RQ23) auto mode: reference off only when all channels down.
// (RQ24) select 00..11 map to channels a..d, bit 18 upper.
// (RQ25) reset: outputs zero-scale, reference enabled in auto mode.
// (RQ26) power-down mode taken from leading data bits.
`timescale 1ns/100ps
module qdc_top import qdc_pkg::*; #(
    parameter int N_CH = NUM_CH
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // serial link pins
    input  wire logic                    frame_sel_n,
    input  wire logic                    sclk,
    input  wire logic                    din,
    // address straps
    input  wire logic                    addr_strap_hi,
    input  wire logic                    addr_strap_lo,
    // channel outputs
    output qdc_entry_s [NUM_CH-1:0]      chan_out,
    // reference control
    output logic                         ref_out_en,
    output logic                         ref_powered,
    output qdc_ref_e                     ref_mode,
    // frame status pulses
    output logic                         word_done,
    output logic                         frame_abort
);

    // ========================================================
    // decode helpers
    // ========================================================

    // compare a locked word with a reference command, nibble ignored
    function automatic logic is_ref_cmd(input logic [WORD_W-1:0] w,
                                        input logic [WORD_W-1:0] c);
        is_ref_cmd = (w[WORD_W-1:CODE_LSB] == c[WORD_W-1:CODE_LSB]);
    endfunction

    // channel number to one-hot strobe
    function automatic logic [NUM_CH-1:0] ch_onehot(
        input logic [1:0] sel);
        ch_onehot = NUM_CH'(1) << sel;
    endfunction

    // ========================================================
    // state
    // ========================================================
    qdc_top_s   st_q;
    qdc_top_s   st_d;

    // filtered pin levels and their edges
    logic [NUM_PIN-1:0] flt_nx;
    logic       sync_lvl;
    logic       sclk_fall;
    logic       sync_fall;
    logic       sync_rise;

    // fields of the locked word
    logic [1:0]        ld_code;
    logic [1:0]        ch_sel;
    logic              pd_sel;
    logic [CODE_W-1:0] code_fld;
    logic              is_bcast;
    logic              addr_hit;
    logic              is_ref;

    // bank strobes
    logic [NUM_CH-1:0] wr_buf;
    logic [NUM_CH-1:0] ld_out;
    logic [NUM_CH-1:0] ld_new;
    qdc_entry_s        new_entry;
    qdc_entry_s [NUM_CH-1:0] out_q;
    qdc_entry_s [NUM_CH-1:0] buf_q;
    logic              any_up;

    // ========================================================
    // edge finding on filtered levels
    // ========================================================

    // a level counts once stages two and three agree;
    // built from st_q only so the edges never loop through st_d
    always_comb begin
        for (int p = 0; p < NUM_PIN; p++) begin
            flt_nx[p] = (st_q.s2[p] == st_q.s3[p]) ? st_q.s3[p]
                                                   : st_q.flt[p];
        end
        sync_lvl  = st_q.flt[PIN_SYNC];
        sclk_fall = st_q.flt[PIN_SCLK] & ~flt_nx[PIN_SCLK];
        sync_fall = st_q.flt[PIN_SYNC] & ~flt_nx[PIN_SYNC];
        sync_rise = ~st_q.flt[PIN_SYNC] & flt_nx[PIN_SYNC];
    end

    // ========================================================
    // word fields
    // ========================================================
    // (RQ1) control, data, ignored nibble
    assign ld_code  = st_q.sreg[BIT_LD_HI:BIT_LD_LO];
    // (RQ12) (RQ24) channel select, bit 18 upper
    assign ch_sel   = st_q.sreg[BIT_SEL_HI:BIT_SEL_LO];
    // (RQ13) power-down select
    assign pd_sel   = st_q.sreg[BIT_PD_SEL];
    // (RQ9) straight binary code, no conversion
    assign code_fld = st_q.sreg[CODE_MSB:CODE_LSB];
    // (RQ17) broadcast skips address match
    assign is_bcast = (ld_code == LD_BCAST);
    // (RQ10) straps must match bits 23 and 22
    assign addr_hit = is_bcast ||
                      ((st_q.sreg[BIT_ADDR_HI] == addr_strap_hi) &&
                       (st_q.sreg[BIT_ADDR_LO] == addr_strap_lo));
    assign is_ref   = is_ref_cmd(st_q.sreg, REF_CMD_AUTO) ||
                      is_ref_cmd(st_q.sreg, REF_CMD_ON) ||
                      is_ref_cmd(st_q.sreg, REF_CMD_OFF);

    // (RQ26) power-down mode from the leading data bits
    always_comb begin
        new_entry.pd      = pd_sel;
        new_entry.pd_mode = pd_sel ? code_fld[CODE_W-1 -: PD_MODE_W]
                                   : '0;
        new_entry.code    = code_fld;
    end

    // ========================================================
    // command decode into bank strobes
    // ========================================================
    always_comb begin
        wr_buf = '0;
        ld_out = '0;
        ld_new = '0;
        // (RQ5) act in the cycle after the lock
        if (st_q.exec && addr_hit && !is_ref) begin
            case (ld_code)
                // (RQ14) buffer only
                LD_STORE: begin
                    wr_buf = ch_onehot(ch_sel);
                end
                // (RQ15) buffer and output register
                LD_SINGLE: begin
                    wr_buf = ch_onehot(ch_sel);
                    ld_out = ch_onehot(ch_sel);
                    ld_new = ch_onehot(ch_sel);
                end
                // (RQ16) selected new, others from buffers
                LD_SIMUL: begin
                    wr_buf = ch_onehot(ch_sel);
                    ld_out = '1;
                    ld_new = ch_onehot(ch_sel);
                end
                LD_BCAST: begin
                    ld_out = '1;
                    if (ch_sel[1]) begin
                        // (RQ19) word to all channels
                        wr_buf = '1;
                        ld_new = '1;
                    end
                    // (RQ18) otherwise all outputs from buffers
                end
                default: begin
                    wr_buf = '0;
                end
            endcase
        end
    end

    // ========================================================
    // channel storage
    // ========================================================
    qdc_bank u_bank (
        .clk       (clk),
        .rst       (rst),
        .wr_buf    (wr_buf),
        .ld_out    (ld_out),
        .ld_new    (ld_new),
        .new_entry (new_entry),
        .out_q     (out_q),
        .buf_q     ()
    );

    // any channel powered up keeps the auto reference alive
    always_comb begin
        any_up = 1'b0;
        for (int i = 0; i < N_CH; i++) begin
            any_up = any_up | ~out_q[i].pd;
        end
    end

    // ========================================================
    // frame engine and reference mode
    // ========================================================
    always_comb begin
        st_d       = st_q;
        // three-stage pin sampler
        st_d.s1    = {din, sclk, frame_sel_n};
        st_d.s2    = st_q.s1;
        st_d.s3    = st_q.s2;
        st_d.flt   = flt_nx;
        st_d.exec  = 1'b0;
        st_d.done  = 1'b0;
        st_d.abort = 1'b0;

        case (st_q.st)
            ST_IDLE: begin
                // (RQ3) frame select falling opens the frame
                if (sync_fall) begin
                    st_d.st  = ST_SHIFT;
                    st_d.cnt = '0;
                end
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    // (RQ6) partial word dropped
                    st_d.st    = ST_IDLE;
                    st_d.abort = 1'b1;
                end else if (sclk_fall && !sync_lvl) begin
                    // (RQ2) msb first, shift towards bit 23
                    st_d.sreg = {st_q.sreg[WORD_W-2:0], st_q.flt[PIN_DIN]};
                    st_d.cnt  = st_q.cnt + CNT_W'(1);
                    // (RQ4) 24th edge locks the word
                    if (st_q.cnt == WORD_LAST) begin
                        st_d.st   = ST_LOCK;
                        st_d.exec = 1'b1;
                        st_d.done = 1'b1;
                    end
                end
            end
            ST_LOCK: begin
                // (RQ7) only a new falling select restarts
                if (sync_fall) begin
                    st_d.st  = ST_SHIFT;
                    st_d.cnt = '0;
                end
            end
            default: begin
                st_d.st = ST_IDLE;
            end
        endcase

        // reference commands ignore straps but must match bits 23 to 4, load bits included
        if (st_q.exec) begin
            // (RQ20) back to automatic mode
            if (is_ref_cmd(st_q.sreg, REF_CMD_AUTO)) begin
                st_d.ref_mode = REF_AUTO;
            end
            // (RQ21) always powered
            if (is_ref_cmd(st_q.sreg, REF_CMD_ON)) begin
                st_d.ref_mode = REF_ON;
            end
            // (RQ22) disabled, output tri-stated
            if (is_ref_cmd(st_q.sreg, REF_CMD_OFF)) begin
                st_d.ref_mode = REF_OFF;
            end
        end

        // (RQ23) auto mode follows channel power
        case (st_q.ref_mode)
            REF_AUTO: st_d.ref_pwr = any_up;
            REF_ON:   st_d.ref_pwr = 1'b1;
            REF_OFF:  st_d.ref_pwr = 1'b0;
            default:  st_d.ref_pwr = 1'b1;
        endcase
    end

    // (RQ25) reference starts enabled in auto mode
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q          <= '0;
            st_q.s1       <= '1;
            st_q.s2       <= '1;
            st_q.s3       <= '1;
            st_q.flt      <= '1;
            st_q.st       <= ST_IDLE;
            st_q.ref_mode <= REF_AUTO;
            st_q.ref_pwr  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // outputs, all from flip-flops
    // ========================================================
    assign chan_out    = out_q;
    assign ref_mode    = st_q.ref_mode;
    assign ref_powered = st_q.ref_pwr;
    assign ref_out_en  = st_q.ref_pwr;
    assign word_done   = st_q.done;
    assign frame_abort = st_q.abort;

endmodule // qdc_top

// File: common/qdc_pkg.sv
package qdc_pkg;

    // ========================================================
    // serial word layout
    // ========================================================
    localparam int WORD_W       = 24;
    localparam int CNT_W        = 5;
    localparam logic [CNT_W-1:0] WORD_LAST = 5'h17; // 24th bit index
    localparam int BIT_ADDR_HI  = 23;
    localparam int BIT_ADDR_LO  = 22;
    localparam int BIT_LD_HI    = 21;
    localparam int BIT_LD_LO    = 20;
    localparam int BIT_SEL_HI   = 18;
    localparam int BIT_SEL_LO   = 17;
    localparam int BIT_PD_SEL   = 16;
    localparam int CODE_MSB     = 15;
    localparam int CODE_LSB     = 4;
    localparam int CODE_W       = 12;
    localparam int PD_MODE_W    = 2;
    localparam int NUM_CH       = 4;

    // ========================================================
    // reference command words (low nibble is don't care)
    // ========================================================
    localparam logic [23:0] REF_CMD_AUTO = 24'h010000;
    localparam logic [23:0] REF_CMD_ON   = 24'h011000;
    localparam logic [23:0] REF_CMD_OFF  = 24'h012000;

    // ========================================================
    // load control codes {load_ctrl_hi, load_ctrl_lo}
    // ========================================================
    localparam logic [1:0] LD_STORE = 2'h0;
    localparam logic [1:0] LD_SINGLE = 2'h1;
    localparam logic [1:0] LD_SIMUL = 2'h2;
    localparam logic [1:0] LD_BCAST = 2'h3;

    // ========================================================
    // pin sampler indices and timing
    // ========================================================
    localparam int PIN_SYNC = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DIN  = 2;
    localparam int NUM_PIN  = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_MAX_MHZ  = 50;

    // ========================================================
    // types
    // ========================================================
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_LOCK  = 3'h4
    } qdc_frame_e;

    typedef enum logic [2:0] {
        REF_AUTO = 3'h1,
        REF_ON   = 3'h2,
        REF_OFF  = 3'h4
    } qdc_ref_e;

    // one channel word: power-down flag, mode, code
    typedef struct packed {
        logic                 pd;
        logic [PD_MODE_W-1:0] pd_mode;
        logic [CODE_W-1:0]    code;
    } qdc_entry_s;

    localparam qdc_entry_s ENTRY_RST = '0;

    typedef struct packed {
        qdc_entry_s [NUM_CH-1:0] bufs;
        qdc_entry_s [NUM_CH-1:0] outs;
    } qdc_bank_s;

    typedef struct packed {
        logic [NUM_PIN-1:0] s1;
        logic [NUM_PIN-1:0] s2;
        logic [NUM_PIN-1:0] s3;
        logic [NUM_PIN-1:0] flt;
        qdc_frame_e         st;
        logic [CNT_W-1:0]   cnt;
        logic [WORD_W-1:0]  sreg;
        logic               exec;
        logic               done;
        logic               abort;
        qdc_ref_e           ref_mode;
        logic               ref_pwr;
    } qdc_top_s;

endpackage

// File: verilog/qdc_bank.sv
`timescale 1ns/100ps
module qdc_bank import qdc_pkg::*; (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // update strobes, one bit per channel
    input  wire logic [NUM_CH-1:0]       wr_buf,
    input  wire logic [NUM_CH-1:0]       ld_out,
    input  wire logic [NUM_CH-1:0]       ld_new,
    input  qdc_entry_s                   new_entry,
    // registered channel state
    output qdc_entry_s [NUM_CH-1:0]      out_q,
    output qdc_entry_s [NUM_CH-1:0]      buf_q
);

    // ========================================================
    // channel buffers and output registers
    // ========================================================
    qdc_bank_s bank_q;
    qdc_bank_s bank_d;

    // output reg takes the old buffer unless told to take new word
    always_comb begin
        bank_d = bank_q;
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr_buf[i]) begin
                bank_d.bufs[i] = new_entry;
            end
            if (ld_out[i]) begin
                bank_d.outs[i] = ld_new[i] ? new_entry : bank_q.bufs[i];
            end
        end
    end

    // zero-scale, powered up after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_q <= {2*NUM_CH{ENTRY_RST}};
        end else begin
            bank_q <= bank_d;
        end
    end

    assign out_q = bank_q.outs;
    assign buf_q = bank_q.bufs;

endmodule // qdc_bank

// File: test/qdc_top_asserts.sv
`timescale 1ns/100ps
module qdc_top_asserts import qdc_pkg::*; #(
    parameter int N_CH = NUM_CH
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // serial pins and straps
    input wire logic               frame_sel_n,
    input wire logic               sclk,
    input wire logic               din,
    input wire logic               addr_strap_hi,
    input wire logic               addr_strap_lo,
    // outputs under watch
    input qdc_entry_s [NUM_CH-1:0] chan_out,
    input wire logic               ref_out_en,
    input wire logic               ref_powered,
    input qdc_ref_e                ref_mode,
    input wire logic               word_done,
    input wire logic               frame_abort
);
    logic any_up;

    // auto mode wants the reference while any channel runs
    assign any_up = !(chan_out[0].pd && chan_out[1].pd
                      && chan_out[2].pd && chan_out[3].pd);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ========================================================
    // frame handling
    // ========================================================
    a_done_single: assert property (word_done |=> !word_done [*8])
        else $error("word_done not a lone pulse");
    a_done_no_wait: assert property (word_done |-> !frame_sel_n)
        else $error("word_done waited for frame end");
    a_abort_excl: assert property (!(word_done && frame_abort))
        else $error("abort and done together");
    a_abort_cause: assert property (
        frame_abort |-> frame_sel_n && $past(frame_sel_n, 2))
        else $error("abort without frame select rise");
    a_abort_quiet: assert property (
        frame_abort |=> $stable(chan_out) [*2])
        else $error("outputs moved after abort");

    // ========================================================
    // updates and reference
    // ========================================================
    a_out_cause: assert property (
        $changed(chan_out) |-> $past(word_done))
        else $error("channel output moved without a word");
    a_mode_cause: assert property (
        $changed(ref_mode) |-> $past(word_done))
        else $error("reference mode moved without a word");
    a_ref_off: assert property (
        (ref_mode == REF_OFF) [*2] |-> !ref_powered && !ref_out_en)
        else $error("reference alive while disabled");
    a_ref_on: assert property (
        (ref_mode == REF_ON) [*2] |-> ref_powered)
        else $error("reference down while forced on");
    a_ref_auto: assert property (
        (ref_mode == REF_AUTO && $stable(chan_out)) [*2]
        |-> ref_powered == any_up)
        else $error("auto reference power wrong");
    a_en_tracks: assert property (ref_out_en == ref_powered)
        else $error("reference pin enable off its power");

    c_done: cover property (word_done);
    c_abort: cover property (frame_abort);
    c_all_down: cover property (!any_up);
    c_ref_off: cover property (ref_mode == REF_OFF);
endmodule // qdc_top_asserts

// File: test/qdc_host.sv
`timescale 1ns/100ps
module qdc_host import qdc_pkg::*; (
    // clock seen by the host
    input  wire logic clk,
    // serial link pins toward the block
    output logic      frame_sel_n,
    output logic      sclk,
    output logic      din
);
    // idle: select high, clock parked high
    initial begin
        frame_sel_n = 1'b1;
        sclk        = 1'b1;
        din         = 1'b0;
    end

    // msb first, data set while sclk high
    // four clk per phase keeps sclk well under 50 MHz
    task automatic xfer(input logic [23:0] w, input int nb);
        @(negedge clk);
        frame_sel_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            // bits past the word toggle so a leak would show
            din = (i < WORD_W) ? w[23-i] : i[0];
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            sclk = 1'b1;
        end
        // released data line inverts, never keeps a stale bit
        din = ~din;
        repeat (4) @(negedge clk);
        frame_sel_n = 1'b1;
        // idle gap before any next frame
        repeat (8) @(negedge clk);
    endtask
endmodule // qdc_host

// File: test/qdc_top_bench.sv
`timescale 1ns/100ps
module qdc_top_bench import qdc_pkg::*;;
    logic                    clk;
    logic                    rst;
    logic                    frame_sel_n;
    logic                    sclk;
    logic                    din;
    logic                    addr_strap_hi;
    logic                    addr_strap_lo;
    logic                    ref_out_en;
    logic                    ref_powered;
    logic                    word_done;
    logic                    frame_abort;
    qdc_entry_s [NUM_CH-1:0] chan_out;
    qdc_entry_s [NUM_CH-1:0] exp_out;
    qdc_entry_s [NUM_CH-1:0] exp_buf;
    qdc_ref_e                ref_mode;
    qdc_ref_e                exp_mode;
    int                      error_cnt = 0;
    int                      comparisons = 0;
    int                      done_n = 0;
    int                      abort_n = 0;
    int                      cyc = 0;

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    qdc_top #(.N_CH(NUM_CH)) uut (
        .clk(clk), .rst(rst), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .din(din), .addr_strap_hi(addr_strap_hi),
        .addr_strap_lo(addr_strap_lo), .chan_out(chan_out),
        .ref_out_en(ref_out_en), .ref_powered(ref_powered),
        .ref_mode(ref_mode), .word_done(word_done),
        .frame_abort(frame_abort));

    qdc_host host (.clk(clk), .frame_sel_n(frame_sel_n), .sclk(sclk),
                   .din(din));

    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (word_done === 1'b1) done_n++;
        if (frame_abort === 1'b1) abort_n++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ========================================================
    // reference model and checks
    // ========================================================
    function automatic logic exp_pwr();
        logic up;
        up = 1'b0;
        for (int i = 0; i < NUM_CH; i++) up |= !exp_out[i].pd;
        return (exp_mode == REF_ON) || (exp_mode == REF_AUTO && up);
    endfunction

    // decode one word into the expected channel state
    task automatic apply(input logic [23:0] w);
        qdc_entry_s e;
        int         s;
        e.pd = w[16];
        e.pd_mode = w[16] ? w[15:14] : 2'h0;
        e.code = w[15:4];
        s = int'(w[18:17]);
        if (w[23:4] == REF_CMD_AUTO[23:4]) exp_mode = REF_AUTO;
        else if (w[23:4] == REF_CMD_ON[23:4]) exp_mode = REF_ON;
        else if (w[23:4] == REF_CMD_OFF[23:4]) exp_mode = REF_OFF;
        else if (w[21:20] == LD_BCAST) begin
            if (w[18]) exp_buf = {NUM_CH{e}};
            exp_out = exp_buf;
        end else if (w[23:22] == {addr_strap_hi, addr_strap_lo}) begin
            exp_buf[s] = e;
            if (w[21:20] == LD_SINGLE) exp_out[s] = e;
            if (w[21:20] == LD_SIMUL) exp_out = exp_buf;
        end
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic check_all();
        chk(64'(chan_out), 64'(exp_out));
        chk(64'(ref_mode), 64'(exp_mode));
        chk(64'(ref_powered), 64'(exp_pwr()));
        chk(64'(ref_out_en), 64'(exp_pwr()));
    endtask

    // one frame of nb bits, then judge the result
    task automatic send(input logic [23:0] w, input int nb);
        int n0;
        n0 = done_n;
        host.xfer(w, nb);
        if (nb >= WORD_W) apply(w);
        chk(64'(done_n - n0), (nb >= WORD_W) ? 64'h1 : 64'h0);
        check_all();
    endtask

    // bit 19 always sent as zero
    function automatic logic [23:0] mk(input logic [1:0] ld, input int ch,
                                       input logic pd, input logic [11:0] d);
        return {addr_strap_hi, addr_strap_lo, ld, 1'b0, 2'(ch), pd, d, 4'h9};
    endfunction

    // ========================================================
    // scenarios
    // ========================================================
    task automatic t_loads();
        for (int c = 0; c < NUM_CH; c++)
            send(mk(LD_STORE, c, 1'b0, 12'h100 + 12'(c)), 24);
        send(mk(LD_SINGLE, 1, 1'b0, 12'hfff), 24);
        send(mk(LD_SINGLE, 1, 1'b0, 12'h000), 24);
        send(mk(LD_SIMUL, 3, 1'b0, 12'habc), 24);
    endtask

    task automatic t_address();
        send(mk(LD_SINGLE, 0, 1'b0, 12'h777) ^ 24'h400000, 24);
        send(mk(LD_STORE, 2, 1'b0, 12'h777) ^ 24'h800000, 24);
        send(mk(LD_STORE, 0, 1'b0, 12'h321), 24);
        send(mk(LD_BCAST, 0, 1'b0, 12'heee) ^ 24'hc00000, 24);
        send(mk(LD_BCAST, 2, 1'b0, 12'h456) ^ 24'h400000, 24);
    endtask

    task automatic t_power();
        for (int c = 0; c < NUM_CH; c++)
            send(mk(LD_SINGLE, c, 1'b1, {2'(c), 10'h0}), 24);
        send(REF_CMD_ON, 24);
        send(REF_CMD_OFF, 24);
        send(REF_CMD_AUTO, 24);
        send(mk(LD_SINGLE, 3, 1'b0, 12'h800), 24);
    endtask

    task automatic t_frames();
        int n0;
        n0 = abort_n;
        send(mk(LD_SINGLE, 0, 1'b0, 12'h999), 23);
        chk(64'(abort_n - n0), 64'h1);
        send(mk(LD_SINGLE, 2, 1'b0, 12'h5a5), 30);
    endtask

    task automatic complete_run();
        $display("errors %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        addr_strap_hi = 1'b1;
        addr_strap_lo = 1'b0;
        exp_out = '0;
        exp_buf = '0;
        exp_mode = REF_AUTO;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check_all();
        t_loads();
        t_address();
        t_power();
        t_frames();
        complete_run();
    end
endmodule // qdc_top_bench

bind qdc_top qdc_top_asserts #(.N_CH(N_CH)) u_chk (
    .clk(clk), .rst(rst), .frame_sel_n(frame_sel_n), .sclk(sclk),
    .din(din), .addr_strap_hi(addr_strap_hi),
    .addr_strap_lo(addr_strap_lo), .chan_out(chan_out),
    .ref_out_en(ref_out_en), .ref_powered(ref_powered),
    .ref_mode(ref_mode), .word_done(word_done),
    .frame_abort(frame_abort));
